// File: lf_autozero_pacer.sv
// Counts data edges and paces auto-zero requests during a data frame.
// Assumes data_edge is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
`include "lf_frontend_params.svh"
module lf_autozero_pacer (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       enable,
	input  wire logic       data_edge,
	input  wire logic       data_level,
	input  wire logic [2:0] edge_target,
	input  wire logic [1:0] trigger_mode,
	output logic            request,
	output logic [2:0]      edge_count
);
	logic [2:0] dither;
	logic [3:0] target_eff;
	logic       reached;
	logic       level_ok;
	logic       fire;

	// ----------------------------------------
	// Threshold and level gate
	// ----------------------------------------
	assign target_eff = (trigger_mode != lf_frontend_pkg::TRIG_DITHER) ? {1'b0, edge_target} :
		(dither[1:0] == 2'h0 && edge_target != 3'h0) ? {1'b0, edge_target} - 4'h1 :
		(dither[1:0] == 2'h2) ? {1'b0, edge_target} + 4'h1 : {1'b0, edge_target};
	assign reached  = {1'b0, edge_count} >= target_eff;
	assign level_ok = (trigger_mode == lf_frontend_pkg::TRIG_EDGES_LOW)  ? !data_level :
		(trigger_mode == lf_frontend_pkg::TRIG_EDGES_HIGH) ? data_level : 1'b1;
	assign fire     = enable && reached && level_ok && !request;

	// ----------------------------------------
	// Edge counter and request
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst || !enable) begin
			edge_count <= 3'h0;
			request    <= 1'b0;
		end else begin
			request <= fire;
			if (fire) begin
				edge_count <= 3'h0;
			end else if (data_edge && edge_count != `EDGE_COUNT_MAX) begin
				edge_count <= edge_count + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dither <= 3'h1;
		end else if (fire) begin
			dither <= {dither[1:0], dither[2] ^ dither[1]};
		end
	end
endmodule : lf_autozero_pacer

// File: lf_frontend_chk.sv
// Port checker for the LF front-end configuration bank.
// Assumes one clock SYS_CLK and a synchronous active-high RST.
`timescale 1ns/1ns
module lf_frontend_chk (
	input wire logic        SYS_CLK,
	input wire logic        RST,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic [31:0] DAT_O,
	input wire logic        ACK_O,
	input wire logic        DATA_MODE,
	input wire logic        CARRIER_MODE,
	input wire logic [1:0]  THIRD_AMP_GAIN,
	input wire logic [2:0]  AMP_GAIN_FACTOR,
	input wire logic [1:0]  FINAL_STAGE_SELECT,
	input wire logic        LOGARITHMIC_AMPLIFIER_PROGRAMMABLE,
	input wire logic        FOURTH_RECTIFIER_ENABLE,
	input wire logic        DATA_AUTOZERO_ENABLE,
	input wire logic [1:0]  DEQ_RESISTOR_SELECT,
	input wire logic [9:0]  DEQ_RESISTOR_OHMS_X10,
	input wire logic [1:0]  SLICER_HYSTERESIS,
	input wire logic [5:0]  HYSTERESIS_MV,
	input wire logic        FILTER_MODE_HI,
	input wire logic        FILTER_MODE_LO,
	input wire logic        BIPHASE_FILTER_ENABLE,
	input wire logic        BIPHASE_HIGH_OFFSET,
	input wire logic        AUTOZERO_REQUEST,
	input wire logic        DECODED_BIT_VALID
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_ack_single: assert property (ACK_O |=> !ACK_O)
		else $error("ack held longer than one cycle");
	a_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I) && CYC_I && STB_I)
		else $error("ack without a request");
	a_read_byte: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_gain_map: assert property (AMP_GAIN_FACTOR == (THIRD_AMP_GAIN == 2'h0 ? 3'h2 :
		THIRD_AMP_GAIN == 2'h1 ? 3'h3 : THIRD_AMP_GAIN == 2'h2 ? 3'h4 : 3'h6))
		else $error("gain factor does not match code");
	a_final_map: assert property (LOGARITHMIC_AMPLIFIER_PROGRAMMABLE == (FINAL_STAGE_SELECT == 2'h1) &&
		FOURTH_RECTIFIER_ENABLE == !FINAL_STAGE_SELECT[1])
		else $error("final stage flags do not match code");
	a_deq_map: assert property (DEQ_RESISTOR_OHMS_X10 == (DEQ_RESISTOR_SELECT == 2'h0 ? 10'h190 :
		DEQ_RESISTOR_SELECT == 2'h1 ? 10'h0C8 : DEQ_RESISTOR_SELECT == 2'h2 ? 10'h064 : 10'h032))
		else $error("resistor value does not match code");
	a_slicer_hysteresis_map: assert property (HYSTERESIS_MV == (SLICER_HYSTERESIS == 2'h0 ? 6'h14 :
		SLICER_HYSTERESIS == 2'h1 ? 6'h28 : SLICER_HYSTERESIS == 2'h2 ? 6'h32 : 6'h1E))
		else $error("hysteresis value does not match code");
	a_filter_map: assert property (BIPHASE_FILTER_ENABLE == FILTER_MODE_HI &&
		BIPHASE_HIGH_OFFSET == (FILTER_MODE_HI && FILTER_MODE_LO))
		else $error("filter flags do not match mode");
	a_az_cause: assert property (AUTOZERO_REQUEST |-> DATA_AUTOZERO_ENABLE && $past(DATA_MODE)
		&& !$past(CARRIER_MODE) ##1 !AUTOZERO_REQUEST)
		else $error("auto-zero request while not allowed");
	a_dec_mode: assert property (DECODED_BIT_VALID |-> $past(DATA_MODE) && !$past(CARRIER_MODE))
		else $error("decoded bit in carrier mode");

	// ----------------------------------------
	// Covers
	// ----------------------------------------
	c_ack: cover property (ACK_O);
	c_az: cover property (AUTOZERO_REQUEST);
	c_dec: cover property (DECODED_BIT_VALID);
endmodule : lf_frontend_chk

bind lf_receiver_frontend_config lf_frontend_chk chk_u (.SYS_CLK(SYS_CLK), .RST(RST), .CYC_I(CYC_I),
	.STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .DATA_MODE(DATA_MODE), .CARRIER_MODE(CARRIER_MODE),
	.THIRD_AMP_GAIN(THIRD_AMP_GAIN), .AMP_GAIN_FACTOR(AMP_GAIN_FACTOR),
	.FINAL_STAGE_SELECT(FINAL_STAGE_SELECT), .LOGARITHMIC_AMPLIFIER_PROGRAMMABLE(LOGARITHMIC_AMPLIFIER_PROGRAMMABLE),
	.FOURTH_RECTIFIER_ENABLE(FOURTH_RECTIFIER_ENABLE), .DATA_AUTOZERO_ENABLE(DATA_AUTOZERO_ENABLE),
	.DEQ_RESISTOR_SELECT(DEQ_RESISTOR_SELECT), .DEQ_RESISTOR_OHMS_X10(DEQ_RESISTOR_OHMS_X10),
	.SLICER_HYSTERESIS(SLICER_HYSTERESIS), .HYSTERESIS_MV(HYSTERESIS_MV),
	.FILTER_MODE_HI(FILTER_MODE_HI), .FILTER_MODE_LO(FILTER_MODE_LO),
	.BIPHASE_FILTER_ENABLE(BIPHASE_FILTER_ENABLE), .BIPHASE_HIGH_OFFSET(BIPHASE_HIGH_OFFSET),
	.AUTOZERO_REQUEST(AUTOZERO_REQUEST), .DECODED_BIT_VALID(DECODED_BIT_VALID));

// File: lf_frontend_params.svh
// Offsets, field positions, reset values and counts of the LF front-end config bank.
// Assumes a Wishbone slave decoding byte addresses, one 32-bit word per register.
`ifndef LF_FRONTEND_PARAMS_SVH
`define LF_FRONTEND_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PAGE_CONTROL    8'h00
`define OFS_FRONTEND        8'h04
`define OFS_FILTER_POL      8'h08
`define OFS_STATUS          8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_PAGE_SELECT     0
`define POS_TRIGGER_LO      1
`define POS_CARRIER_LO      3
`define POS_GAIN_LO         6
`define POS_FINAL_LO        4
`define POS_AZ_ENABLE       3
`define POS_DEQ_RES_LO      1
`define POS_DEQ_ENABLE      0
`define POS_SLICER_HYSTERESIS_LO         6
`define POS_FILTER_LO       4
`define POS_POLARITY        3
`define POS_EDGE_COUNT_LO   0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PAGE_CONTROL    8'h00
`define RST_FRONTEND        8'h00
`define RST_FILTER_POL      8'h00

// ----------------------------------------
// Counts
// ----------------------------------------
`define EDGE_COUNT_MAX      3'h7
`define SYNC_STAGES         3

`endif

// File: lf_frontend_pkg.sv
// Types shared by the LF front-end config bank.
// Assumes the constants header is included by users needing numbers.
package lf_frontend_pkg;

	// ----------------------------------------
	// Bus answer states
	// ----------------------------------------
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_type;

	// ----------------------------------------
	// Auto-zero trigger modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		TRIG_EDGES      = 2'h0,
		TRIG_DITHER     = 2'h1,
		TRIG_EDGES_LOW  = 2'h2,
		TRIG_EDGES_HIGH = 2'h3
	} trigger_mode_type;

endpackage : lf_frontend_pkg

// File: lf_pin_sync.sv
// Three-stage synchroniser for an input pin.
// Assumes the pin is asynchronous to clk; output moves when stages two and three agree.
`timescale 1ns/1ns
module lf_pin_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level
);
	logic s1;
	logic s2;
	logic s3;

	// ----------------------------------------
	// Stages
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				level <= s3;
			end
		end
	end
endmodule : lf_pin_sync

// File: lf_receiver_frontend_config.sv
// LF receiver front-end configuration bank with Wishbone classic slave.
// Assumes a single 25 MHz clock, synchronous reset, and an asynchronous demodulated data pin.
// Assumes software sets the page bit before it touches the two paged registers.
`timescale 1ns/1ns
`include "lf_frontend_params.svh"

module lf_receiver_frontend_config (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [31:0] DAT_I,
	input  wire logic        WE_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic        STB_I,
	input  wire logic        CYC_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	input  wire logic        DATA_IN,
	input  wire logic        DATA_MODE,
	input  wire logic        CARRIER_MODE,
	input  wire logic        MID_BIT_WINDOW,
	output logic      [1:0]  THIRD_AMP_GAIN,
	output logic      [2:0]  AMP_GAIN_FACTOR,
	output logic      [1:0]  FINAL_STAGE_SELECT,
	output logic             LOGARITHMIC_AMPLIFIER_PROGRAMMABLE,
	output logic             FOURTH_RECTIFIER_ENABLE,
	output logic             DATA_AUTOZERO_ENABLE,
	output logic      [1:0]  DEQ_RESISTOR_SELECT,
	output logic      [9:0]  DEQ_RESISTOR_OHMS_X10,
	output logic             DEQ_SYSTEM_ENABLE,
	output logic      [1:0]  SLICER_HYSTERESIS,
	output logic      [5:0]  HYSTERESIS_MV,
	output logic             FILTER_MODE_HI,
	output logic             FILTER_MODE_LO,
	output logic             BIPHASE_FILTER_ENABLE,
	output logic             BIPHASE_HIGH_OFFSET,
	output logic             MANCHESTER_POLARITY,
	output logic             NARROW_CARRIER_TOLERANCE,
	output logic             AUTOZERO_REQUEST,
	output logic             DECODED_BIT_VALID,
	output logic             DECODED_BIT
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [2:0] gain_factor(input logic [1:0] code);
		case (code)
			2'h0:    gain_factor = 3'h2;
			2'h1:    gain_factor = 3'h3;
			2'h2:    gain_factor = 3'h4;
			default: gain_factor = 3'h6;
		endcase
	endfunction : gain_factor

	function automatic logic [5:0] slicer_hysteresis_mv(input logic [1:0] code);
		case (code)
			2'h0:    slicer_hysteresis_mv = 6'h14;
			2'h1:    slicer_hysteresis_mv = 6'h28;
			2'h2:    slicer_hysteresis_mv = 6'h32;
			default: slicer_hysteresis_mv = 6'h1E;
		endcase
	endfunction : slicer_hysteresis_mv

	function automatic logic [9:0] deq_ohms_x10(input logic [1:0] code);
		case (code)
			2'h0:    deq_ohms_x10 = 10'h190;
			2'h1:    deq_ohms_x10 = 10'h0C8;
			2'h2:    deq_ohms_x10 = 10'h064;
			default: deq_ohms_x10 = 10'h032;
		endcase
	endfunction : deq_ohms_x10

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] data,
		input logic lane);
		merge_byte = lane ? data[7:0] : old;
	endfunction : merge_byte

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	lf_frontend_pkg::bus_state_type bus_state;
	lf_frontend_pkg::bus_state_type next_bus_state;
	logic [7:0]  page_control;
	logic [7:0]  lf_frontend_control;
	logic [7:0]  lf_filter_polarity_control;
	logic [7:0]  next_page_control;
	logic [7:0]  next_frontend;
	logic [7:0]  next_filter_pol;
	logic [31:0] next_dat;
	logic [3:0]  autozero_count;
	logic        data_level;
	logic        data_level_d;
	logic        data_edge;
	logic [2:0]  edge_count;
	logic        az_request;
	logic        last_bit;

	// ----------------------------------------
	// Field views
	// ----------------------------------------
	wire         register_page_select  = page_control[`POS_PAGE_SELECT];
	wire [1:0]   autozero_trigger_mode = page_control[`POS_TRIGGER_LO +: 2];
	wire [1:0]   carrier_check_method  = page_control[`POS_CARRIER_LO +: 2];
	wire [1:0]   third_amp_gain        = lf_frontend_control[`POS_GAIN_LO +: 2];
	wire [1:0]   final_stage_select    = lf_frontend_control[`POS_FINAL_LO +: 2];
	wire         data_autozero_enable  = lf_frontend_control[`POS_AZ_ENABLE];
	wire [1:0]   deq_resistor_select   = lf_frontend_control[`POS_DEQ_RES_LO +: 2];
	wire         deq_system_enable     = lf_frontend_control[`POS_DEQ_ENABLE];
	wire [1:0]   slicer_hysteresis     = lf_filter_polarity_control[`POS_SLICER_HYSTERESIS_LO +: 2];
	wire         filter_mode_hi        = lf_filter_polarity_control[`POS_FILTER_LO + 1];
	wire         filter_mode_lo        = lf_filter_polarity_control[`POS_FILTER_LO];
	wire         manchester_polarity   = lf_filter_polarity_control[`POS_POLARITY];
	wire [2:0]   autozero_edge_count   = lf_filter_polarity_control[`POS_EDGE_COUNT_LO +: 3];

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire         bus_req      = CYC_I && STB_I;
	wire         bus_commit   = bus_req && (bus_state == lf_frontend_pkg::BUS_ACK);
	wire         hit_page     = ADR_I == `OFS_PAGE_CONTROL;
	wire         hit_frontend = ADR_I == `OFS_FRONTEND;
	wire         hit_filter   = ADR_I == `OFS_FILTER_POL;
	wire         hit_status   = ADR_I == `OFS_STATUS;
	wire         paged_ok     = register_page_select;
	wire         rd_frontend  = hit_frontend && paged_ok;
	wire         rd_filter    = hit_filter && paged_ok;
	wire [7:0]   status_byte  = {autozero_count, edge_count, last_bit};

	// ----------------------------------------
	// Write strobes
	// ----------------------------------------
	wire         wr_commit     = bus_commit && WE_I;
	wire         wr_page       = wr_commit && hit_page;
	wire         wr_frontend   = wr_commit && hit_frontend && paged_ok;
	wire         wr_filter     = wr_commit && hit_filter && paged_ok;
	wire         lane_page     = wr_page && SEL_I[0];
	wire         lane_frontend = wr_frontend && SEL_I[0];
	wire         lane_filter   = wr_filter && SEL_I[0];

	// ----------------------------------------
	// Bus answer state
	// ----------------------------------------
	always_comb begin
		case (bus_state)
			lf_frontend_pkg::BUS_IDLE: begin
				if (bus_req) begin
					next_bus_state = lf_frontend_pkg::BUS_ACK;
				end else begin
					next_bus_state = lf_frontend_pkg::BUS_IDLE;
				end
			end
			lf_frontend_pkg::BUS_ACK: begin
				next_bus_state = lf_frontend_pkg::BUS_IDLE;
			end
			default: begin
				next_bus_state = lf_frontend_pkg::BUS_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Read select and write merge
	// ----------------------------------------
	assign next_dat =
		hit_page    ? {24'h000000, page_control} :
		rd_frontend ? {24'h000000, lf_frontend_control} :
		rd_filter   ? {24'h000000, lf_filter_polarity_control} :
		hit_status  ? {24'h000000, status_byte} :
		32'h00000000;

	assign next_page_control = merge_byte(page_control, DAT_I, lane_page);
	assign next_frontend     = merge_byte(lf_frontend_control, DAT_I, lane_frontend);
	assign next_filter_pol   = merge_byte(lf_filter_polarity_control, DAT_I, lane_filter);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			bus_state <= lf_frontend_pkg::BUS_IDLE;
			DAT_O     <= 32'h00000000;
		end else begin
			bus_state <= next_bus_state;
			if (next_bus_state == lf_frontend_pkg::BUS_ACK) begin
				DAT_O <= next_dat;
			end
		end
	end

	assign ACK_O = bus_req && (bus_state == lf_frontend_pkg::BUS_ACK);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			page_control               <= `RST_PAGE_CONTROL;
			lf_frontend_control        <= `RST_FRONTEND;
			lf_filter_polarity_control <= `RST_FILTER_POL;
		end else begin
			page_control               <= next_page_control;
			lf_frontend_control        <= next_frontend;
			lf_filter_polarity_control <= next_filter_pol;
		end
	end

	// ----------------------------------------
	// Front-end controls
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			THIRD_AMP_GAIN          <= 2'h0;
			AMP_GAIN_FACTOR         <= 3'h2;
			FINAL_STAGE_SELECT      <= 2'h0;
			LOGARITHMIC_AMPLIFIER_PROGRAMMABLE     <= 1'b0;
			FOURTH_RECTIFIER_ENABLE <= 1'b1;
			DATA_AUTOZERO_ENABLE    <= 1'b0;
			DEQ_RESISTOR_SELECT     <= 2'h0;
			DEQ_RESISTOR_OHMS_X10   <= 10'h190;
			DEQ_SYSTEM_ENABLE       <= 1'b0;
		end else begin
			THIRD_AMP_GAIN          <= third_amp_gain;
			AMP_GAIN_FACTOR         <= gain_factor(third_amp_gain);
			FINAL_STAGE_SELECT      <= final_stage_select;
			LOGARITHMIC_AMPLIFIER_PROGRAMMABLE     <= final_stage_select == 2'h1;
			FOURTH_RECTIFIER_ENABLE <= !final_stage_select[1];
			DATA_AUTOZERO_ENABLE    <= data_autozero_enable;
			DEQ_RESISTOR_SELECT     <= deq_resistor_select;
			DEQ_RESISTOR_OHMS_X10   <= deq_ohms_x10(deq_resistor_select);
			DEQ_SYSTEM_ENABLE       <= deq_system_enable;
		end
	end

	// ----------------------------------------
	// Slicer, filter and carrier check
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SLICER_HYSTERESIS        <= 2'h0;
			HYSTERESIS_MV            <= 6'h14;
			FILTER_MODE_HI           <= 1'b0;
			FILTER_MODE_LO           <= 1'b0;
			BIPHASE_FILTER_ENABLE    <= 1'b0;
			BIPHASE_HIGH_OFFSET      <= 1'b0;
			MANCHESTER_POLARITY      <= 1'b0;
			NARROW_CARRIER_TOLERANCE <= 1'b0;
		end else begin
			SLICER_HYSTERESIS        <= slicer_hysteresis;
			HYSTERESIS_MV            <= slicer_hysteresis_mv(slicer_hysteresis);
			FILTER_MODE_HI           <= filter_mode_hi;
			FILTER_MODE_LO           <= filter_mode_lo;
			BIPHASE_FILTER_ENABLE    <= filter_mode_hi;
			BIPHASE_HIGH_OFFSET      <= filter_mode_hi && filter_mode_lo;
			MANCHESTER_POLARITY      <= manchester_polarity;
			NARROW_CARRIER_TOLERANCE <= carrier_check_method == 2'h1 ||
				carrier_check_method == 2'h2;
		end
	end

	// ----------------------------------------
	// Data input and edge detect
	// ----------------------------------------
	lf_pin_sync data_sync (
		.clk   (SYS_CLK),
		.rst   (RST),
		.pin   (DATA_IN),
		.level (data_level)
	);

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			data_level_d <= 1'b0;
		end else begin
			data_level_d <= data_level;
		end
	end

	assign data_edge = data_level != data_level_d;

	// ----------------------------------------
	// Manchester mid-bit decode
	// ----------------------------------------
	wire         rising_edge  = data_level && !data_level_d;
	wire         decode_take  = data_edge && MID_BIT_WINDOW && DATA_MODE && !CARRIER_MODE;
	wire         decoded      = rising_edge ^ manchester_polarity;

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			DECODED_BIT_VALID <= 1'b0;
			DECODED_BIT       <= 1'b0;
			last_bit          <= 1'b0;
		end else begin
			DECODED_BIT_VALID <= decode_take;
			if (decode_take) begin
				DECODED_BIT <= decoded;
				last_bit    <= decoded;
			end
		end
	end

	// ----------------------------------------
	// Auto-zero pacing in data frames
	// ----------------------------------------
	wire         az_enable = DATA_MODE && !CARRIER_MODE && data_autozero_enable;

	lf_autozero_pacer az_pacer (
		.clk          (SYS_CLK),
		.rst          (RST),
		.enable       (az_enable),
		.data_edge    (data_edge),
		.data_level   (data_level),
		.edge_target  (autozero_edge_count),
		.trigger_mode (autozero_trigger_mode),
		.request      (az_request),
		.edge_count   (edge_count)
	);

	assign AUTOZERO_REQUEST = az_request;

	// ----------------------------------------
	// Auto-zero request count
	// ----------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			autozero_count <= 4'h0;
		end else if (az_request) begin
			autozero_count <= autozero_count + 4'h1;
		end
	end

endmodule : lf_receiver_frontend_config

// File: lf_receiver_frontend_config_test.sv
// Self-checking bench for the LF front-end configuration bank.
// Assumes the Wishbone answer and field lags given by the design.
`timescale 1ns/1ns
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD %s exp %0h got %0h", n, e, a); end end
module lf_receiver_frontend_config_test;
	logic        clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, din = 0, dmode = 0, cmode = 0, win = 1;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, dat_o, q;
	logic [3:0]  sel = 4'h0;
	logic        ack, azr, dv, db, lp, fr, aze, den, fhi, flo, bpe, bph, mp, nct;
	logic [1:0]  g, fs, ds, hs;
	logic [2:0]  gfa;
	logic [9:0]  ohm;
	logic [5:0]  mv;
	logic [2:0]  gf[4] = '{3'h2, 3'h3, 3'h4, 3'h6};
	logic [9:0]  om[4] = '{10'h190, 10'h0C8, 10'h064, 10'h032};
	logic [5:0]  hv[4] = '{6'h14, 6'h28, 6'h32, 6'h1E};
	int          fail_count = 0, n_tests = 0, az_n = 0, dv_n = 0, i, k;
	logic        last_bit;

	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (azr === 1'b1) az_n++;
		if (dv === 1'b1) begin dv_n++; last_bit = db; end
	end

	lf_receiver_frontend_config dut_u (.SYS_CLK(clk), .RST(rst), .ADR_I(adr), .DAT_I(wdat), .WE_I(we),
		.SEL_I(sel), .STB_I(stb), .CYC_I(cyc), .DAT_O(dat_o), .ACK_O(ack), .DATA_IN(din), .DATA_MODE(dmode),
		.CARRIER_MODE(cmode), .MID_BIT_WINDOW(win), .THIRD_AMP_GAIN(g), .AMP_GAIN_FACTOR(gfa),
		.FINAL_STAGE_SELECT(fs), .LOGARITHMIC_AMPLIFIER_PROGRAMMABLE(lp), .FOURTH_RECTIFIER_ENABLE(fr),
		.DATA_AUTOZERO_ENABLE(aze), .DEQ_RESISTOR_SELECT(ds), .DEQ_RESISTOR_OHMS_X10(ohm),
		.DEQ_SYSTEM_ENABLE(den), .SLICER_HYSTERESIS(hs), .HYSTERESIS_MV(mv), .FILTER_MODE_HI(fhi),
		.FILTER_MODE_LO(flo), .BIPHASE_FILTER_ENABLE(bpe), .BIPHASE_HIGH_OFFSET(bph),
		.MANCHESTER_POLARITY(mp), .NARROW_CARRIER_TOLERANCE(nct), .AUTOZERO_REQUEST(azr),
		.DECODED_BIT_VALID(dv), .DECODED_BIT(db));

	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// One classic cycle; waits for ack and takes data at that edge
	task bus(input logic [7:0] a, input logic [7:0] d, input logic w, input logic s);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d}; sel <= {3'h0, s};
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		q = dat_o;
		if (i == 20) begin fail_count++; end_of_test; end
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, d, 1'b1, 1'b1);
		repeat (2) @(posedge clk);
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		bus(a, 8'h00, 1'b0, 1'b0);
		`CHK("read", {24'h0, e}, q)
	endtask : rd

	task edges(input int n);
		repeat (n) begin din <= ~din; repeat (8) @(posedge clk); end
	endtask : edges

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(8'h04, 8'h00); rd(8'h08, 8'h00); rd(8'h00, 8'h00);
		`CHK("gfac", 3'h2, gfa) `CHK("mv", 6'h14, mv) `CHK("ohm", 10'h190, ohm)
		`CHK("pol", 1'b0, mp)
		$display("reset test done");
		wr(8'h04, 8'hFF); rd(8'h04, 8'h00);
		wr(8'h00, 8'h01); rd(8'h04, 8'h00); rd(8'h00, 8'h01);
		bus(8'h04, 8'hFF, 1'b1, 1'b0); rd(8'h04, 8'h00); wr(8'h10, 8'hFF); rd(8'h10, 8'h00);
		$display("page test done");
		for (k = 0; k < 4; k++) begin
			wr(8'h04, {k[1:0], k[1:0], k[0], k[1:0], k[0]});
			rd(8'h04, {k[1:0], k[1:0], k[0], k[1:0], k[0]});
			`CHK("gain", k[1:0], g) `CHK("gfac", gf[k], gfa)
			`CHK("fin", k[1:0], fs) `CHK("prog", k == 1, lp) `CHK("rect", !k[1], fr)
			`CHK("az", k[0], aze)
			`CHK("deq", k[1:0], ds) `CHK("ohm", om[k], ohm)
			`CHK("deq_system_enable", k[0], den)
			wr(8'h08, {k[1:0], k[1:0], k[0], 3'h6});
			rd(8'h08, {k[1:0], k[1:0], k[0], 3'h6});
			`CHK("slicer_hysteresis", k[1:0], hs) `CHK("mv", hv[k], mv)
			`CHK("fhi", k[1], fhi) `CHK("flo", k[0], flo) `CHK("bpe", k[1], bpe) `CHK("bph", k == 3, bph)
			`CHK("pol", k[0], mp)
			wr(8'h00, {3'h0, k[1:0], 2'h0, 1'b1});
			`CHK("narrow", k == 1 || k == 2, nct)
		end
		$display("field test done");
		rst <= 1'b1; repeat (3) @(posedge clk); rst <= 1'b0;
		wr(8'h00, 8'h01); rd(8'h04, 8'h00); rd(8'h08, 8'h00); `CHK("gfac", 3'h2, gfa)
		`CHK("pol", 1'b0, mp)
		$display("mid-run reset test done");
		wr(8'h00, 8'h01); wr(8'h08, 8'h06); wr(8'h04, 8'h08);
		dmode <= 1'b1;
		edges(5); `CHK("az5", 0, az_n)
		edges(1); `CHK("az6", 1, az_n)
		cmode <= 1'b1; edges(6); `CHK("azcar", 1, az_n)
		cmode <= 1'b0; wr(8'h04, 8'h00); edges(6); `CHK("azoff", 1, az_n)
		wr(8'h00, 8'h07); wr(8'h04, 8'h08); edges(6); `CHK("azhi0", 1, az_n)
		edges(1); `CHK("azhi1", 2, az_n)
		wr(8'h00, 8'h05); edges(6); `CHK("azlo0", 2, az_n)
		edges(1); `CHK("azlo1", 3, az_n)
		wr(8'h04, 8'h00);
		$display("auto-zero test done");
		for (k = 0; k < 2; k++) begin
			wr(8'h08, {4'h0, k[0], 3'h6}); dv_n = 0;
			edges(1); `CHK("dvn", 1, dv_n) `CHK("bit", din ^ k[0], last_bit)
			edges(1); `CHK("bit", din ^ k[0], last_bit)
		end
		win <= 1'b0; edges(1); `CHK("dvwin", 2, dv_n)
		win <= 1'b1; cmode <= 1'b1; edges(2); `CHK("dvcar", 2, dv_n)
		rd(8'h0C, {az_n[3:0], 3'h0, last_bit});
		$display("decode test done");
		end_of_test;
	end
endmodule : lf_receiver_frontend_config_test
